/* File: shared/fllk_pkg.sv */
// constants, opcodes and state layout of the flash lock and reset command logic
// assumes a 40 MHz system clock that oversamples the host serial clock
package fllk_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_BLOCK_LOCK   = 8'h36;
	localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
	localparam logic [7:0] OP_LOCK_READ    = 8'h3D;
	localparam logic [7:0] OP_GLOBAL_LOCK  = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLK  = 8'h98;
	localparam logic [7:0] OP_ENABLE_RESET = 8'h66;
	localparam logic [7:0] OP_RESET        = 8'h99;
	localparam logic [7:0] OP_PARAM_READ   = 8'h5A;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_BITS    = 6'h08;
	localparam logic [5:0] ADDR3_BITS = 6'h18;
	localparam logic [5:0] ADDR4_BITS = 6'h20;
	localparam logic [5:0] CNT_SAT    = 6'h3C;
	localparam int         BLK_W      = 8;
	localparam int         NUM_BLK    = 256;
	localparam int         BLK_SHIFT  = 16;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic       CS_IDLE         = 1'b1;
	localparam logic       LOCK_RESET_VAL  = 1'b0;
	localparam int         CLK_PERIOD_NS   = 25;
	localparam int         RST_RECOVERY_NS = 12000;
	localparam int         RST_CYC         = (RST_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] RST_LOAD        = 9'(RST_CYC - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic               cs_s1;
		logic               cs_s2;
		logic               cs_prev;
		logic               ck_s1;
		logic               ck_s2;
		logic               ck_prev;
		logic [3:0]         io_s1;
		logic [3:0]         io_s2;
		logic [5:0]         cnt;
		logic [7:0]         op;
		logic [31:0]        addr;
		logic [2:0]         phase;
		logic               armed;
		logic               recovering;
		logic [8:0]         rst_cnt;
		logic               soft_reset;
		logic [NUM_BLK-1:0] locks;
		logic [3:0]         io_out;
		logic [3:0]         io_oe;
		logic               pe_valid;
		logic               pe_grant;
		logic               sfdp_active;
		logic [31:0]        sfdp_addr;
	} fllk_state_s;

endpackage

/* File: sim/flash_lock_and_reset_commands_tb_top.sv */
// self-checking bench of the lock, reset and parameter-read command logic
// assumes fllk_pkg and fllk_cmd are compiled first; fllk_host drives the pins
`timescale 1ns/1ps

module flash_lock_and_reset_commands_tb_top;
	logic         clk, reset_n, cs_n, sclk, soft_reset, recovering, sfdp_active;
	logic         quad_command_mode, dtr_mode, four_byte_mode, continuous_fetch_mode;
	logic         protect_scheme_select, pe_request, pe_valid, pe_grant;
	logic [3:0]   io_in, io_out, io_oe;
	logic [4:0]   protect_range_bits;
	logic [31:0]  pe_addr, sfdp_addr, sf_seen;
	logic [255:0] lk;
	logic [15:0]  seed;
	logic [7:0]   r, b;
	int           n_mismatch, comparisons, n_srst, n_rec, e_srst;

	fllk_cmd u_fllk_cmd (.clk, .reset_n, .cs_n, .sclk, .io_in, .io_out, .io_oe, .quad_command_mode,
		.dtr_mode, .four_byte_mode, .continuous_fetch_mode, .protect_scheme_select,
		.protect_range_bits, .pe_request, .pe_addr, .pe_valid, .pe_grant, .soft_reset,
		.recovering, .sfdp_active, .sfdp_addr);
	fllk_host u_fllk_host (.clk, .io_out, .io_oe, .cs_n, .sclk, .io_in);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (soft_reset === 1'b1) n_srst++;
		if (recovering === 1'b1) n_rec++;
		if (sfdp_active === 1'b1) sf_seen = sfdp_addr;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic exp_grant(input logic [7:0] blk);
		if (protect_scheme_select == 1'b0) return ~lk[blk];
		if (protect_range_bits == 5'h00) return 1'b1;
		if (protect_range_bits > 5'h09) return 1'b0;
		return int'(blk) < 256 - (1 << (int'(protect_range_bits) - 1));
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] blk, input int nrd);
		seed = lfsr(seed);
		u_fllk_host.frame(op, {seed[15:8], blk, seed}, four_byte_mode ? 32 : 24, 1'b0, nrd, r);
	endtask

	task automatic query(input logic [7:0] blk);
		seed = lfsr(seed);
		@(posedge clk);
		pe_request <= 1'b1;
		pe_addr    <= {seed[15:8], blk, seed};
		@(posedge clk);
		pe_request <= 1'b0;
		@(negedge clk);
		cmp({30'h0, pe_valid, pe_grant}, {30'h0, 1'b1, exp_grant(blk)});
	endtask

	task automatic chk_lock(input logic [7:0] blk);
		cmd(fllk_pkg::OP_LOCK_READ, blk, 8);
		cmp({24'h0, r}, {31'h0, lk[blk]});
		query(blk);
	endtask

	// bounded wait for recovery to end, then reset and recovery counts
	task automatic settle();
		for (int i = 0; i < 600 && recovering !== 1'b0; i++) @(posedge clk);
		cmp({31'h0, recovering}, 32'h0);
		cmp(n_srst, e_srst);
		cmp(n_rec, e_srst * fllk_pkg::RST_CYC);
	endtask

	initial begin
		#2000000;
		n_mismatch++;
		close_out();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		quad_command_mode = 1'b0;
		dtr_mode = 1'b0;
		four_byte_mode = 1'b0;
		continuous_fetch_mode = 1'b0;
		protect_scheme_select = 1'b0;
		protect_range_bits = 5'h00;
		pe_request = 1'b0;
		pe_addr = 32'h0;
		seed = 16'hB645;
		lk = '0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		b = seed[7:0];
		chk_lock(b);
		for (int k = 0; k < 12; k++) begin
			four_byte_mode <= k[0];
			@(posedge clk);
			seed = lfsr(seed);
			b = seed[7:0];
			lk[b] = seed[9];
			cmd(lk[b] ? fllk_pkg::OP_BLOCK_LOCK : fllk_pkg::OP_BLOCK_UNLOCK, b, 0);
			chk_lock(b);
			chk_lock(b ^ 8'h01);
		end
		u_fllk_host.frame(fllk_pkg::OP_GLOBAL_LOCK, 32'h0, 0, 1'b0, 0, r);
		lk = '1;
		chk_lock(seed[15:8]);
		@(posedge clk) protect_scheme_select <= 1'b1;
		for (int n = 0; n < 11; n++) begin
			@(posedge clk) protect_range_bits <= 5'(n);
			query(8'(255 - ((1 << n) >> 1)));
			query(8'(256 - ((1 << n) >> 1)));
		end
		@(posedge clk) protect_scheme_select <= 1'b0;
		u_fllk_host.frame(fllk_pkg::OP_GLOBAL_UNLK, 32'h0, 0, 1'b0, 0, r);
		lk = '0;
		chk_lock(seed[7:0]);
		cmd(fllk_pkg::OP_BLOCK_LOCK, b, 0);
		u_fllk_host.pair(1'b0);
		e_srst = 1;
		cmd(fllk_pkg::OP_BLOCK_LOCK, b ^ 8'h80, 0);
		lk = '0;
		settle();
		chk_lock(b);
		chk_lock(b ^ 8'h80);
		u_fllk_host.frame(fllk_pkg::OP_ENABLE_RESET, 32'h0, 0, 1'b0, 0, r);
		cmd(fllk_pkg::OP_BLOCK_LOCK, b, 0);
		lk[b] = 1'b1;
		u_fllk_host.frame(fllk_pkg::OP_RESET, 32'h0, 0, 1'b0, 0, r);
		chk_lock(b);
		@(posedge clk) continuous_fetch_mode <= 1'b1;
		u_fllk_host.pair(1'b0);
		@(posedge clk) continuous_fetch_mode <= 1'b0;
		u_fllk_host.pair(1'b1);
		@(posedge clk) dtr_mode <= 1'b1;
		u_fllk_host.pair(1'b0);
		@(posedge clk) dtr_mode <= 1'b0;
		settle();
		@(posedge clk) quad_command_mode <= 1'b1;
		u_fllk_host.recover();
		e_srst = 2;
		lk = '0;
		settle();
		@(posedge clk) quad_command_mode <= 1'b0;
		chk_lock(b);
		@(posedge clk) quad_command_mode <= 1'b1;
		u_fllk_host.frame(fllk_pkg::OP_BLOCK_LOCK, {8'h00, b, 16'h0000}, four_byte_mode ? 32 : 24, 1'b1, 0, r);
		lk[b] = 1'b1;
		u_fllk_host.frame(fllk_pkg::OP_LOCK_READ, {8'h00, b, 16'h0000}, four_byte_mode ? 32 : 24, 1'b1, 2, r);
		cmp({24'h0, r}, {31'h0, lk[b]});
		@(posedge clk) quad_command_mode <= 1'b0;
		@(posedge clk) four_byte_mode <= 1'b1;
		@(posedge clk);
		cmd(fllk_pkg::OP_PARAM_READ, b, 2);
		cmp(sf_seen, {seed[15:8], b, seed});
		close_out();
	end
endmodule // flash_lock_and_reset_commands_tb_top

/* File: sim/fllk_host.sv */
// host controller model: frames commands on the serial pins
// assumes clk is the device clock; sclk is clk/8 and idles low between frames
`timescale 1ns/1ps

module fllk_host (
	input  wire logic       clk,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe,
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] io_in
);
	logic [3:0] hv;

	// pin level: device drive wins where enabled; no pulls, so host lines toggle
	assign io_in = (io_oe & io_out) | (~io_oe & hv);

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		hv   = 4'h0;
	end

	// ----------------------------------------------------------------
	// frame tasks
	// ----------------------------------------------------------------
	// answer picked late in the high phase, after the fall update has landed
	task automatic tick(input logic [3:0] d, output logic [3:0] q);
		hv <= d;
		repeat (4) @(posedge clk);
		sclk <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) q = io_in;
		@(posedge clk) sclk <= 1'b0;
	endtask

	task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int nb,
		input logic quad, input int nrd, output logic [7:0] rd);
		logic [39:0] sh;
		logic [3:0]  q;
		sh = (nb == 24) ? {op, ad[23:0], 8'h00} : {op, ad};
		rd = 8'h00;
		@(posedge clk) cs_n <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8 + nb; i += (quad ? 4 : 1)) begin
			tick(quad ? sh[39 - i -: 4] : {~hv[3:1], sh[39 - i]}, q);
		end
		for (int i = 0; i < nrd; i++) begin
			tick(~hv, q);
			rd = {rd[6:0], quad ? q[0] : q[1]};
		end
		@(posedge clk) cs_n <= 1'b1;
		hv <= ~hv;
		repeat (8) @(posedge clk);
	endtask

	// the bench only resets with no program or erase pending
	task automatic pair(input logic quad);
		logic [7:0] r;
		frame(fllk_pkg::OP_ENABLE_RESET, 32'h0, 0, quad, 0, r);
		frame(fllk_pkg::OP_RESET, 32'h0, 0, quad, 0, r);
	endtask

	// unknown mode exit: 8 clocks all lines high, quad pair, single pair
	task automatic recover();
		logic [7:0] r;
		frame(8'hFF, 32'hFFFFFFFF, 24, 1'b1, 0, r);
		pair(1'b1);
		pair(1'b0);
	endtask
endmodule // fllk_host

/* File: verilog/fllk_cmd.sv */
// lock bits, two-frame software reset and parameter-read decode of a serial flash
// assumes cs_n, sclk and io_in come straight from pins; all other inputs are on clk
`timescale 1ns/1ps

module fllk_cmd (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe,
	input  wire logic        quad_command_mode,
	input  wire logic        dtr_mode,
	input  wire logic        four_byte_mode,
	input  wire logic        continuous_fetch_mode,
	input  wire logic        protect_scheme_select,
	input  wire logic [4:0]  protect_range_bits,
	input  wire logic        pe_request,
	input  wire logic [31:0] pe_addr,
	output logic             pe_valid,
	output logic             pe_grant,
	output logic             soft_reset,
	output logic             recovering,
	output logic             sfdp_active,
	output logic      [31:0] sfdp_addr
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	fllk_pkg::fllk_state_s r;
	fllk_pkg::fllk_state_s next_r;

	localparam int BLKW = fllk_pkg::BLK_W;

	logic             in_frame;
	logic             frame_start;
	logic             frame_end;
	logic             ck_rise;
	logic             ck_fall;
	logic             sample_edge;
	logic             quad_frame;
	logic [5:0]       addr_len;
	logic             addr_done;
	logic             op_only;
	logic [BLKW-1:0]  lock_idx;
	logic [7:0]       rd_byte;
	logic [BLKW-1:0]  pe_idx;
	logic [8:0]       range_top;
	logic             range_prot;
	logic             pe_protected;
	logic             addr_hold;

	assign in_frame    = !r.cs_s2;
	assign frame_start = r.cs_prev && !r.cs_s2;
	assign frame_end   = !r.cs_prev && r.cs_s2;
	assign ck_rise     = r.ck_s2 && !r.ck_prev;
	assign ck_fall     = !r.ck_s2 && r.ck_prev;
	// double-rate framing samples on both edges of the serial clock
	assign sample_edge = ck_rise || (dtr_mode && ck_fall);
	// a pair sent in the other mode's framing decodes as a different opcode
	assign quad_frame  = quad_command_mode || dtr_mode;
	assign addr_len    = four_byte_mode ? fllk_pkg::ADDR4_BITS : fllk_pkg::ADDR3_BITS;
	assign addr_done   = r.cnt >= (fllk_pkg::OP_BITS + addr_len);
	assign op_only     = r.cnt == fllk_pkg::OP_BITS;
	// read frames keep a complete address; dummy and data clocks must not shift it
	assign addr_hold   = addr_done && (r.op == fllk_pkg::OP_LOCK_READ || r.op == fllk_pkg::OP_PARAM_READ);
	assign lock_idx    = r.addr[fllk_pkg::BLK_SHIFT +: BLKW];
	assign rd_byte     = {7'h00, r.locks[lock_idx]};
	assign pe_idx      = pe_addr[fllk_pkg::BLK_SHIFT +: BLKW];

	// protect range: value n from 1 to 9 guards the top 2^(n-1) blocks; any value above 9 guards all 256
	always_comb begin
		if (protect_range_bits == 5'h00) begin
			range_top = 9'h000;
		end else if (protect_range_bits > 5'h09) begin
			range_top = 9'h100;
		end else begin
			range_top = 9'h001 << (protect_range_bits - 5'h01);
		end
	end

	assign range_prot   = ({1'b0, pe_idx} + range_top) >= 9'h100;
	assign pe_protected = protect_scheme_select ? range_prot : r.locks[pe_idx];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		// pins pass two flops before anything looks at them
		next_r.cs_s1   = cs_n;
		next_r.cs_s2   = r.cs_s1;
		next_r.cs_prev = r.cs_s2;
		next_r.ck_s1   = sclk;
		next_r.ck_s2   = r.ck_s1;
		next_r.ck_prev = r.ck_s2;
		next_r.io_s1   = io_in;
		next_r.io_s2   = r.io_s1;
		next_r.soft_reset = 1'b0;
		next_r.pe_valid   = 1'b0;

		if (pe_request) begin
			next_r.pe_valid = 1'b1;
			next_r.pe_grant = !pe_protected;
		end

		if (r.recovering) begin
			if (r.rst_cnt == 9'h000) begin
				next_r.recovering = 1'b0;
			end else begin
				next_r.rst_cnt = r.rst_cnt - 9'h001;
			end
		end

		if (frame_start) begin
			next_r.cnt   = 6'h00;
			next_r.op    = 8'h00;
			next_r.addr  = 32'h0000_0000;
			next_r.phase = 3'h0;
		end else if (in_frame && sample_edge && !addr_hold) begin
			if (r.cnt < fllk_pkg::OP_BITS) begin
				next_r.op = quad_frame ? {r.op[3:0], r.io_s2} : {r.op[6:0], r.io_s2[0]};
			end else begin
				next_r.addr = quad_frame ? {r.addr[27:0], r.io_s2} : {r.addr[30:0], r.io_s2[0]};
			end
			if (r.cnt < fllk_pkg::CNT_SAT) begin
				next_r.cnt = r.cnt + (quad_frame ? 6'h04 : 6'h01);
			end
		end

		// lock state goes out on falling edges, msb first, repeating until frame end
		if (in_frame && ck_fall && r.op == fllk_pkg::OP_LOCK_READ && addr_done && !r.recovering) begin
			if (quad_frame) begin
				next_r.io_oe  = 4'hF;
				next_r.io_out = r.phase[0] ? rd_byte[3:0] : rd_byte[7:4];
			end else begin
				next_r.io_oe  = 4'h2;
				next_r.io_out = {2'b00, rd_byte[3'h7 - r.phase], 1'b0};
			end
			next_r.phase = r.phase + 3'h1;
		end

		if (in_frame && addr_done && r.op == fllk_pkg::OP_PARAM_READ && !r.recovering) begin
			next_r.sfdp_active = 1'b1;
			next_r.sfdp_addr   = r.addr;
		end

		if (frame_end) begin
			next_r.io_oe       = 4'h0;
			next_r.io_out      = 4'h0;
			next_r.sfdp_active = 1'b0;
			// empty frames leave the arming alone; the mode-exit clocks count bits and clear it
			if (!r.recovering && r.cnt != 6'h00) begin
				next_r.armed = 1'b0;
				case (r.op)
					fllk_pkg::OP_GLOBAL_LOCK: begin
						if (op_only) begin
							next_r.locks = '1;
						end
					end
					fllk_pkg::OP_GLOBAL_UNLK: begin
						if (op_only) begin
							next_r.locks = '0;
						end
					end
					fllk_pkg::OP_BLOCK_LOCK: begin
						if (addr_done) begin
							next_r.locks[lock_idx] = 1'b1;
						end
					end
					fllk_pkg::OP_BLOCK_UNLOCK: begin
						if (addr_done) begin
							next_r.locks[lock_idx] = 1'b0;
						end
					end
					fllk_pkg::OP_ENABLE_RESET: begin
						next_r.armed = op_only;
					end
					fllk_pkg::OP_RESET: begin
						// continuous read must be left first, so reset is held off there
						if (op_only && r.armed && !continuous_fetch_mode) begin
							next_r.locks      = {fllk_pkg::NUM_BLK{fllk_pkg::LOCK_RESET_VAL}};
							next_r.soft_reset = 1'b1;
							next_r.recovering = 1'b1;
							next_r.rst_cnt    = fllk_pkg::RST_LOAD;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r         <= '0;
			r.cs_s1   <= fllk_pkg::CS_IDLE;
			r.cs_s2   <= fllk_pkg::CS_IDLE;
			r.cs_prev <= fllk_pkg::CS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign io_out      = r.io_out;
	assign io_oe       = r.io_oe;
	assign pe_valid    = r.pe_valid;
	assign pe_grant    = r.pe_grant;
	assign soft_reset  = r.soft_reset;
	assign recovering  = r.recovering;
	assign sfdp_active = r.sfdp_active;
	assign sfdp_addr   = r.sfdp_addr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_cmd_end(logic [7:0] code);
		frame_end && !r.recovering && r.op == code;
	endsequence

	sequence s_reset_accept;
		s_cmd_end(fllk_pkg::OP_RESET) and (op_only && r.armed && !continuous_fetch_mode);
	endsequence

	property p_global_lock;
		s_cmd_end(fllk_pkg::OP_GLOBAL_LOCK) and op_only |=> (&r.locks);
	endproperty
	a_global_lock: assert property (p_global_lock) else $error("global lock left a block unlocked");

	property p_global_unlock;
		s_cmd_end(fllk_pkg::OP_GLOBAL_UNLK) and op_only |=> (r.locks == '0);
	endproperty
	a_global_unlock: assert property (p_global_unlock) else $error("global unlock left a block locked");

	property p_block_lock;
		s_cmd_end(fllk_pkg::OP_BLOCK_LOCK) and addr_done |=> r.locks[$past(lock_idx)];
	endproperty
	a_block_lock: assert property (p_block_lock) else $error("block lock did not set its bit");

	property p_block_unlock;
		s_cmd_end(fllk_pkg::OP_BLOCK_UNLOCK) and addr_done |=> !r.locks[$past(lock_idx)];
	endproperty
	a_block_unlock: assert property (p_block_unlock) else $error("block unlock did not clear its bit");

	property p_reset_seq;
		s_reset_accept |=> soft_reset ##1 (!soft_reset && recovering && r.locks == '0);
	endproperty
	a_reset_seq: assert property (p_reset_seq) else $error("accepted reset pair did not reset");

	property p_reset_armed;
		$rose(soft_reset) |-> $past(r.armed) && $past(r.op) == fllk_pkg::OP_RESET;
	endproperty
	a_reset_armed: assert property (p_reset_armed) else $error("reset without arming frame");

	property p_recover_hold;
		$rose(recovering) |-> recovering [*8];
	endproperty
	a_recover_hold: assert property (p_recover_hold) else $error("recovery interval ended early");

	property p_reject_busy;
		frame_end && r.recovering |=> $stable(r.locks) && !soft_reset;
	endproperty
	a_reject_busy: assert property (p_reject_busy) else $error("command taken during recovery");

	property p_xip_reset;
		frame_end && continuous_fetch_mode && r.op == fllk_pkg::OP_RESET |=> !soft_reset;
	endproperty
	a_xip_reset: assert property (p_xip_reset) else $error("reset taken in continuous read");

	property p_pe_locked;
		pe_request && !protect_scheme_select && r.locks[pe_idx] |=> pe_valid && !pe_grant;
	endproperty
	a_pe_locked: assert property (p_pe_locked) else $error("locked block granted");

	property p_pe_range;
		pe_request && protect_scheme_select && protect_range_bits == 5'h00 |=> pe_valid && pe_grant;
	endproperty
	a_pe_range: assert property (p_pe_range) else $error("lock bit used under range scheme");

	property p_read_lsb;
		in_frame && ck_fall && !quad_frame && r.op == fllk_pkg::OP_LOCK_READ && addr_done
			&& !r.recovering && r.phase == 3'h7 |=> io_oe == 4'h2 && io_out[1] == $past(r.locks[lock_idx]);
	endproperty
	a_read_lsb: assert property (p_read_lsb) else $error("lock read lsb wrong");

	property p_quad_read;
		in_frame && ck_fall && quad_frame && r.op == fllk_pkg::OP_LOCK_READ && addr_done
			&& !r.recovering && r.phase[0] |=> io_oe == 4'hF && io_out == {3'h0, $past(r.locks[lock_idx])};
	endproperty
	a_quad_read: assert property (p_quad_read) else $error("quad lock read nibble wrong");

	property p_read_idle;
		frame_end |=> io_oe == 4'h0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read drive left on after frame");

	property p_soft_pulse;
		soft_reset |=> !soft_reset;
	endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset longer than one cycle");

	property p_recover_end;
		r.recovering && r.rst_cnt == 9'h000 |=> !recovering;
	endproperty
	a_recover_end: assert property (p_recover_end) else $error("recovery interval overran");

	property p_pe_free;
		pe_request && !protect_scheme_select && !r.locks[pe_idx] |=> pe_valid && pe_grant;
	endproperty
	a_pe_free: assert property (p_pe_free) else $error("unlocked block refused");

	property p_pe_full;
		pe_request && protect_scheme_select && protect_range_bits > 5'h09 |=> pe_valid && !pe_grant;
	endproperty
	a_pe_full: assert property (p_pe_full) else $error("full range left a block open");

	property p_sfdp_hold;
		sfdp_active && !frame_end |=> $stable(sfdp_addr);
	endproperty
	a_sfdp_hold: assert property (p_sfdp_hold) else $error("parameter read address moved");

endmodule // fllk_cmd
